// ### pin_strap_regs.svh
// Register offsets, field positions, reset values and timing for the strap loader
`ifndef PIN_STRAP_REGS_SVH
`define PIN_STRAP_REGS_SVH

// Byte offsets on the register bus
`define HS_MODE_OFS 8'h00
`define AUX_MODE_OFS 8'h04
`define RX_SET_OFS 8'h08
`define TERM_PULSE1_OFS 8'h0C
`define TERM_PULSE2_OFS 8'h10
`define RX_EQ1_OFS 8'h14
`define RX_EQ2_OFS 8'h18
`define TX_SET_OFS 8'h1C
`define CTRL_STATUS_OFS 8'h20

// Field positions in the mode registers
`define MODE_ENABLE_BIT 6
`define MODE_SEL_HI 5
`define MODE_SEL_LO 4
`define SRC_SEL_HI 1
`define SRC_SEL_LO 0

// Field positions in the transmitter register
`define TX_EMPH_HI 3
`define TX_EMPH_LO 2
`define TX_BACKTERM_BIT 1
`define TX_CURRENT_BIT 0

// Field positions in the control status register
`define STATUS_STRAP_BIT 0

// Fixed codes
`define QUAD_MODE_CODE 2'h0
`define EQ_HIGH_BYTE 8'hFF
`define EQ_LOW_BYTE 8'h00

// Reset values
`define HS_MODE_RST 8'h00
`define AUX_MODE_RST 8'h40
`define RX_SET_RST 8'h01
`define TERM_PULSE_RST 8'h00
`define RX_EQ_RST 8'h00
`define TX_SET_RST 8'h00

// Synchroniser depth for strap pins
`define SYNC_STAGES 2

`endif

// ### pin_strap_pkg.sv
// Types shared by the strap configuration loader
`default_nettype none
package pin_strap_pkg;

	// Two-bit source pick: A, B, C, D
	typedef logic [1:0] src_sel_t;

	// Eight-bit configuration register
	typedef logic [7:0] cfg_byte_t;

	// Who governs the configuration
	typedef enum logic {
		strap_ctrl,
		serial_ctrl
	} ctrl_mode_e;

endpackage : pin_strap_pkg
`default_nettype wire

// ### strap_bus_if.sv
// Synchronised strap levels passed from the synchroniser to the loader
`timescale 1ns/100ps
`default_nettype none
interface strap_bus_if;
	logic hs_power;
	logic [1:0] source_pick;
	logic input_boost;
	logic [1:0] output_emphasis;
	logic output_backterm;
	logic drive_current;

	// Synchroniser drives the levels
	modport src (
		output hs_power,
		output source_pick,
		output input_boost,
		output output_emphasis,
		output output_backterm,
		output drive_current
	);

	// Loader reads the levels
	modport dst (
		input hs_power,
		input source_pick,
		input input_boost,
		input output_emphasis,
		input output_backterm,
		input drive_current
	);
endinterface : strap_bus_if
`default_nettype wire

// ### strap_sync.sv
// Two-stage synchroniser for the static strap pins
`timescale 1ns/100ps
`default_nettype none
`include "pin_strap_regs.svh"
module strap_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hs_channel_power_strap_i,
	input wire logic [1:0] source_pick_strap_i,
	input wire logic input_boost_strap_i,
	input wire logic [1:0] output_emphasis_strap_i,
	input wire logic output_backterm_strap_i,
	input wire logic drive_current_strap_i,
	strap_bus_if.src straps
);
	import pin_strap_pkg::*;

	localparam int W = 8;

	logic [W-1:0] pins;
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;

	// Gather the pins into one word
	assign pins = {hs_channel_power_strap_i, source_pick_strap_i, input_boost_strap_i,
		output_emphasis_strap_i, output_backterm_strap_i, drive_current_strap_i};

	// First stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage1 <= 8'h00;
			stage2 <= 8'h00;
		end else begin
			stage1 <= pins;
			stage2 <= stage1;
		end
	end

	// Hand the settled levels on
	assign straps.hs_power = stage2[7];
	assign straps.source_pick = stage2[6:5];
	assign straps.input_boost = stage2[4];
	assign straps.output_emphasis = stage2[3:2];
	assign straps.output_backterm = stage2[1];
	assign straps.drive_current = stage2[0];

endmodule : strap_sync
`default_nettype wire

// ### pin_strap_switch_config.sv
// Strap-pin configuration loader for the four-input link switch
//
// Operation
// - Power strap low forces standby, high enables
// - Source strap routes whole lane group
// - Auxiliary switch enabled, quad mode, under straps
// - Source strap also picks auxiliary source
// - Input terminations held on under straps
// - Termination pulsing on switch held off
// - One boost strap: 6 or 12 dB
// - Emphasis strap: 0, 2, 4, 6 dB
// - Backterm strap switches all output terminations
// - Current strap picks 10 or 20 mA
// - Straps govern until first configuration register access (status and unmapped offsets do not end it)
// - High-speed mode fixed quad under straps
// - Output lane takes same input lane
`timescale 1ns/100ps
`default_nettype none
`include "pin_strap_regs.svh"
module pin_strap_switch_config (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hs_channel_power_strap_i,
	input wire logic [1:0] source_pick_strap_i,
	input wire logic input_boost_strap_i,
	input wire logic [1:0] output_emphasis_strap_i,
	input wire logic output_backterm_strap_i,
	input wire logic drive_current_strap_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic hs_enable_o,
	output logic hs_standby_o,
	output logic [1:0] hs_mode_o,
	output pin_strap_pkg::src_sel_t hs_source_o,
	output logic [7:0] hs_lane_sel_o,
	output logic aux_enable_o,
	output logic [1:0] aux_mode_o,
	output pin_strap_pkg::src_sel_t aux_source_o,
	output logic input_term_o,
	output logic [15:0] term_pulse_o,
	output logic [15:0] input_eq_o,
	output logic [1:0] output_emphasis_o,
	output logic output_backterm_o,
	output logic drive_current_o,
	output logic strap_active_o
);
	import pin_strap_pkg::*;

	strap_bus_if straps ();

	ctrl_mode_e mode;
	ctrl_mode_e next_mode;
	cfg_byte_t hs_mode;
	cfg_byte_t aux_mode;
	cfg_byte_t rx_set;
	cfg_byte_t term_pulse1;
	cfg_byte_t term_pulse2;
	cfg_byte_t rx_eq1;
	cfg_byte_t rx_eq2;
	cfg_byte_t tx_set;
	cfg_byte_t next_hs_mode;
	cfg_byte_t next_aux_mode;
	cfg_byte_t next_rx_set;
	cfg_byte_t next_term_pulse1;
	cfg_byte_t next_term_pulse2;
	cfg_byte_t next_rx_eq1;
	cfg_byte_t next_rx_eq2;
	cfg_byte_t next_tx_set;
	cfg_byte_t strap_hs_mode;
	cfg_byte_t strap_aux_mode;
	cfg_byte_t strap_eq;
	cfg_byte_t strap_tx_set;
	cfg_byte_t wr_byte;
	logic [31:0] next_rdata;
	logic req;
	logic wr_en;
	logic cfg_hit;
	logic hit_hs;
	logic hit_aux;
	logic hit_rx;
	logic hit_tp1;
	logic hit_tp2;
	logic hit_eq1;
	logic hit_eq2;
	logic hit_tx;
	logic hit_status;
	logic strap_now;

	// Pin synchroniser
	strap_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.hs_channel_power_strap_i(hs_channel_power_strap_i),
		.source_pick_strap_i(source_pick_strap_i),
		.input_boost_strap_i(input_boost_strap_i),
		.output_emphasis_strap_i(output_emphasis_strap_i),
		.output_backterm_strap_i(output_backterm_strap_i),
		.drive_current_strap_i(drive_current_strap_i),
		.straps(straps)
	);

	// Builds a mode register byte
	function automatic cfg_byte_t mode_byte(input logic en, input logic [1:0] sel,
		input src_sel_t src);
		cfg_byte_t b;
		b = 8'h00;
		b[`MODE_ENABLE_BIT] = en;
		b[`MODE_SEL_HI:`MODE_SEL_LO] = sel;
		b[`SRC_SEL_HI:`SRC_SEL_LO] = src;
		return b;
	endfunction : mode_byte

	// Address match on word boundary
	function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] ofs);
		return {adr[7:2], 2'b00} == ofs;
	endfunction : addr_is

	// Bus request decode
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_en = req & wb_we_i & wb_sel_i[0];
	assign wr_byte = wb_dat_i[7:0];
	assign hit_hs = addr_is(wb_adr_i, `HS_MODE_OFS);
	assign hit_aux = addr_is(wb_adr_i, `AUX_MODE_OFS);
	assign hit_rx = addr_is(wb_adr_i, `RX_SET_OFS);
	assign hit_tp1 = addr_is(wb_adr_i, `TERM_PULSE1_OFS);
	assign hit_tp2 = addr_is(wb_adr_i, `TERM_PULSE2_OFS);
	assign hit_eq1 = addr_is(wb_adr_i, `RX_EQ1_OFS);
	assign hit_eq2 = addr_is(wb_adr_i, `RX_EQ2_OFS);
	assign hit_tx = addr_is(wb_adr_i, `TX_SET_OFS);
	assign hit_status = addr_is(wb_adr_i, `CTRL_STATUS_OFS);
	assign cfg_hit = hit_hs | hit_aux | hit_rx | hit_tp1 | hit_tp2 | hit_eq1 | hit_eq2 | hit_tx;

	always_comb begin
		next_mode = mode;
		case (mode)
			strap_ctrl: begin
				if (req && cfg_hit) begin
					next_mode = serial_ctrl;
				end
			end
			serial_ctrl: begin
				next_mode = serial_ctrl;
			end
			default: begin
				next_mode = strap_ctrl;
			end
		endcase
	end

	assign strap_now = (mode == strap_ctrl) && !(req && cfg_hit);

	assign strap_hs_mode = mode_byte(straps.hs_power, `QUAD_MODE_CODE, straps.source_pick);
	assign strap_aux_mode = mode_byte(1'b1, `QUAD_MODE_CODE, straps.source_pick);
	// one boost level for all inputs
	assign strap_eq = straps.input_boost ? `EQ_HIGH_BYTE : `EQ_LOW_BYTE;
	assign strap_tx_set = {4'h0, straps.output_emphasis, straps.output_backterm,
		straps.drive_current};

	assign next_hs_mode = strap_now ? strap_hs_mode : ((wr_en && hit_hs) ? wr_byte : hs_mode);
	assign next_aux_mode = strap_now ? strap_aux_mode :
		((wr_en && hit_aux) ? wr_byte : aux_mode);
	assign next_rx_set = strap_now ? `RX_SET_RST : ((wr_en && hit_rx) ? wr_byte : rx_set);
	assign next_term_pulse1 = strap_now ? `TERM_PULSE_RST :
		((wr_en && hit_tp1) ? wr_byte : term_pulse1);
	assign next_term_pulse2 = strap_now ? `TERM_PULSE_RST :
		((wr_en && hit_tp2) ? wr_byte : term_pulse2);
	assign next_rx_eq1 = strap_now ? strap_eq : ((wr_en && hit_eq1) ? wr_byte : rx_eq1);
	assign next_rx_eq2 = strap_now ? strap_eq : ((wr_en && hit_eq2) ? wr_byte : rx_eq2);
	assign next_tx_set = strap_now ? strap_tx_set : ((wr_en && hit_tx) ? wr_byte : tx_set);

	// Read data selection, unmapped reads as zero
	assign next_rdata = hit_hs ? {24'h00_0000, hs_mode} :
		hit_aux ? {24'h00_0000, aux_mode} :
		hit_rx ? {24'h00_0000, rx_set} :
		hit_tp1 ? {24'h00_0000, term_pulse1} :
		hit_tp2 ? {24'h00_0000, term_pulse2} :
		hit_eq1 ? {24'h00_0000, rx_eq1} :
		hit_eq2 ? {24'h00_0000, rx_eq2} :
		hit_tx ? {24'h00_0000, tx_set} :
		hit_status ? {31'h0000_0000, mode == strap_ctrl} :
		32'h0000_0000;

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= strap_ctrl;
			hs_mode <= `HS_MODE_RST;
			aux_mode <= `AUX_MODE_RST;
			rx_set <= `RX_SET_RST;
			term_pulse1 <= `TERM_PULSE_RST;
			term_pulse2 <= `TERM_PULSE_RST;
			rx_eq1 <= `RX_EQ_RST;
			rx_eq2 <= `RX_EQ_RST;
			tx_set <= `TX_SET_RST;
		end else begin
			mode <= next_mode;
			hs_mode <= next_hs_mode;
			aux_mode <= next_aux_mode;
			rx_set <= next_rx_set;
			term_pulse1 <= next_term_pulse1;
			term_pulse2 <= next_term_pulse2;
			rx_eq1 <= next_rx_eq1;
			rx_eq2 <= next_rx_eq2;
			tx_set <= next_tx_set;
		end
	end

	// Bus answer, one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? next_rdata : 32'h0000_0000;
		end
	end

	// Output flops from the next values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hs_enable_o <= 1'b0;
			hs_standby_o <= 1'b1;
			hs_mode_o <= 2'h0;
			hs_source_o <= 2'h0;
			hs_lane_sel_o <= 8'h00;
			aux_enable_o <= 1'b1;
			aux_mode_o <= 2'h0;
			aux_source_o <= 2'h0;
			input_term_o <= 1'b1;
			term_pulse_o <= 16'h0000;
			input_eq_o <= 16'h0000;
			output_emphasis_o <= 2'h0;
			output_backterm_o <= 1'b0;
			drive_current_o <= 1'b0;
			strap_active_o <= 1'b1;
		end else begin
			hs_enable_o <= next_hs_mode[`MODE_ENABLE_BIT];
			hs_standby_o <= ~next_hs_mode[`MODE_ENABLE_BIT];
			hs_mode_o <= next_hs_mode[`MODE_SEL_HI:`MODE_SEL_LO];
			hs_source_o <= next_hs_mode[`SRC_SEL_HI:`SRC_SEL_LO];
			// every lane draws the same source index
			hs_lane_sel_o <= {4{next_hs_mode[`SRC_SEL_HI:`SRC_SEL_LO]}};
			aux_enable_o <= next_aux_mode[`MODE_ENABLE_BIT];
			aux_mode_o <= next_aux_mode[`MODE_SEL_HI:`MODE_SEL_LO];
			aux_source_o <= next_aux_mode[`SRC_SEL_HI:`SRC_SEL_LO];
			input_term_o <= next_rx_set[0];
			term_pulse_o <= {next_term_pulse2, next_term_pulse1};
			input_eq_o <= {next_rx_eq2, next_rx_eq1};
			output_emphasis_o <= next_tx_set[`TX_EMPH_HI:`TX_EMPH_LO];
			output_backterm_o <= next_tx_set[`TX_BACKTERM_BIT];
			drive_current_o <= next_tx_set[`TX_CURRENT_BIT];
			strap_active_o <= (next_mode == strap_ctrl);
		end
	end

endmodule : pin_strap_switch_config
`default_nettype wire

// ### strap_board.sv
// Board model: strap pins tied high or low
`timescale 1ns/100ps
`default_nettype none
module strap_board (
	input wire logic [7:0] tie_i,
	output logic [7:0] pins_o
);
	assign pins_o = tie_i;
endmodule : strap_board
`default_nettype wire

// ### strap_cfg_checker.sv
// Port assertions for the strap configuration loader
`timescale 1ns/100ps
`default_nettype none
module strap_cfg_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hs_channel_power_strap_i,
	input wire logic [1:0] source_pick_strap_i,
	input wire logic input_boost_strap_i,
	input wire logic [1:0] output_emphasis_strap_i,
	input wire logic output_backterm_strap_i,
	input wire logic drive_current_strap_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic hs_enable_o,
	input wire logic hs_standby_o,
	input wire logic [1:0] hs_mode_o,
	input wire pin_strap_pkg::src_sel_t hs_source_o,
	input wire logic [7:0] hs_lane_sel_o,
	input wire logic aux_enable_o,
	input wire logic [1:0] aux_mode_o,
	input wire pin_strap_pkg::src_sel_t aux_source_o,
	input wire logic input_term_o,
	input wire logic [15:0] term_pulse_o,
	input wire logic [15:0] input_eq_o,
	input wire logic [1:0] output_emphasis_o,
	input wire logic output_backterm_o,
	input wire logic drive_current_o,
	input wire logic strap_active_o
);
	import pin_strap_pkg::*;
	logic [2:0] run;
	logic ok;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Cycles since reset left, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i) run <= 3'h0;
		else if (run != 3'h7) run <= run + 3'h1;
	end
	// Straps govern and the sync pipe holds real pin levels
	assign ok = strap_active_o && run == 3'h7;
	// Bus request and its one-cycle answer
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	// Decoded strap levels three edges after the pins
	AST_POWER: assert property (ok |-> hs_enable_o == $past(hs_channel_power_strap_i, 3)
		&& hs_standby_o != hs_enable_o) else $error("channel power wrong");
	AST_SOURCE: assert property (ok |-> hs_source_o == $past(source_pick_strap_i, 3)
		&& hs_lane_sel_o == {4{hs_source_o}}) else $error("source routing wrong");
	AST_AUX: assert property (strap_active_o |-> aux_enable_o && aux_mode_o == 2'h0
		&& aux_source_o == hs_source_o) else $error("aux switch wrong");
	AST_TERM: assert property (strap_active_o |-> input_term_o
		&& term_pulse_o == 16'h0000) else $error("input termination wrong");
	AST_EQ: assert property (ok |-> input_eq_o == {16{$past(input_boost_strap_i, 3)}})
		else $error("equalization wrong");
	AST_TX: assert property (ok |->
		output_emphasis_o == $past(output_emphasis_strap_i, 3)
		&& output_backterm_o == $past(output_backterm_strap_i, 3)
		&& drive_current_o == $past(drive_current_strap_i, 3)) else $error("transmitter wrong");
	AST_MODE: assert property (strap_active_o |-> hs_mode_o == 2'h0)
		else $error("mode not quad");
	// Bus answers, hand-over and no return without reset
	AST_ACK: assert property (req_s |=> ack_s)
		else $error("bus ack wrong");
	AST_END: assert property (req_s ##0 strap_active_o && wb_adr_i[7:2] < 6'h08
		|-> ##[1:2] !strap_active_o) else $error("strap control not ended");
	AST_HOLD: assert property (!strap_active_o |=> !strap_active_o)
		else $error("strap control came back");
endmodule : strap_cfg_checker
bind pin_strap_switch_config strap_cfg_checker chk (.*);
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the strap configuration loader
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
	import pin_strap_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00, tie = 8'h00, pins, hs_lane_sel_o;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rdat;
	logic wb_ack_o, hs_enable_o, hs_standby_o, aux_enable_o, input_term_o, output_backterm_o;
	logic drive_current_o, strap_active_o;
	logic [1:0] hs_mode_o, aux_mode_o, output_emphasis_o;
	src_sel_t hs_source_o, aux_source_o;
	logic [15:0] term_pulse_o, input_eq_o;
	int fails = 0, checks = 0;
	strap_board board (.tie_i(tie), .pins_o(pins));
	pin_strap_switch_config DUT (.hs_channel_power_strap_i(pins[0]), .source_pick_strap_i(pins[2:1]),
		.input_boost_strap_i(pins[3]), .output_emphasis_strap_i(pins[5:4]),
		.output_backterm_strap_i(pins[6]), .drive_current_strap_i(pins[7]), .*);
	// Clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// One classic bus cycle held until ack is sampled high, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		// Timeout ends the run as a failure
		if (n >= 40) begin
			fails++;
			end_sim();
		end else begin
			rdat = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask : wb
	// Let straps pass the sync pipe, sample mid-cycle
	task automatic settle;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
	endtask : settle
	// All outputs against one strap pattern
	task automatic chk_out(input logic [7:0] t);
		`CHK("enable", t[0], hs_enable_o)
		`CHK("standby", ~t[0], hs_standby_o)
		`CHK("source", t[2:1], hs_source_o)
		`CHK("lanes", {4{t[2:1]}}, hs_lane_sel_o)
		`CHK("aux", {1'b1, 2'h0, t[2:1]}, {aux_enable_o, aux_mode_o, aux_source_o})
		`CHK("input term", 17'h1_0000, {input_term_o, term_pulse_o})
		`CHK("eq", {16{t[3]}}, input_eq_o)
		`CHK("emphasis", t[5:4], output_emphasis_o)
		`CHK("backterm current", {t[6], t[7]}, {output_backterm_o, drive_current_o})
		`CHK("mode", 2'h0, hs_mode_o)
		`CHK("strap active", 1'b1, strap_active_o)
		@(posedge clk_i);
	endtask : chk_out
	// Verdict and end of run
	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Watchdog
	initial begin
		repeat (3000) @(posedge clk_i);
		fails++;
		end_sim();
	end
	// Test sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			tie <= {i[1], ~i[0], ~i[1], ~i[0], i[0] ^ i[2], i[1], i[0], i[2]};
			settle();
			chk_out(tie);
		end
		wb(1'b0, 8'h20, 32'h0000_0000);
		`CHK("status", 32'h0000_0001, rdat)
		wb(1'b1, 8'h44, 32'h0000_00FF);
		wb(1'b0, 8'h40, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rdat)
		settle();
		chk_out(tie);
		$display("strap decode test done");
		wb(1'b0, 8'h00, 32'h0000_0000);
		`CHK("hs image", {25'h000_0000, tie[0], 4'h0, tie[2:1]}, rdat)
		tie <= ~tie;
		settle();
		`CHK("held source", 2'h3, hs_source_o)
		`CHK("held enable", 1'b1, hs_enable_o)
		`CHK("strap active", 1'b0, strap_active_o)
		@(posedge clk_i);
		wb(1'b1, 8'h1C, 32'h0000_000D);
		`CHK("tx out", 4'hD, {output_emphasis_o, output_backterm_o, drive_current_o})
		wb(1'b0, 8'h1C, 32'h0000_0000);
		`CHK("tx read", 32'h0000_000D, rdat)
		// Serial writes now govern mode, source and equalization
		wb(1'b1, 8'h00, 32'h0000_0052);
		`CHK("serial mode", 6'h26, {hs_enable_o, hs_standby_o, hs_mode_o, hs_source_o})
		`CHK("serial lanes", 8'hAA, hs_lane_sel_o)
		wb(1'b1, 8'h14, 32'h0000_000F);
		`CHK("serial eq", 16'h000F, input_eq_o)
		$display("bus handover test done");
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		settle();
		chk_out(tie);
		$display("reset return test done");
		end_sim();
	end
endmodule : testbench
`default_nettype wire
